/* File: verilog/sarc_top.sv */
/*
  Sleep-mode control, timed brown-out-off unlock, peripheral clock gates
  and reset combining with a start-up delay counter, behind AXI4-Lite.
  Assumes reset sources come from analog or other-domain logic and are
  synchronised here; the async reset output is used by the I/O ports.
*/
`timescale 1ns/1ps

module sarc_top
    import sarc_pkg::*;
#(
    parameter logic [31:0] TOUT_MID_CYCLES  = SARC_TOUT_MID_US * SARC_CYC_PER_US,
    parameter logic [31:0] TOUT_LONG_CYCLES = SARC_TOUT_LONG_US * SARC_CYC_PER_US
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output      logic             s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output      logic             s_axi_wready,
    output      logic [1:0]       s_axi_bresp,
    output      logic             s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output      logic             s_axi_arready,
    output      logic [31:0]      s_axi_rdata,
    output      logic [1:0]       s_axi_rresp,
    output      logic             s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             sleep_instr,
    input  wire logic             timer2_async_select,
    input  wire logic [1:0]       startup_time_fuse,
    input  wire logic [3:0]       clock_select_fuse,
    input  wire sarc_rst_src_type rst_src,
    output      logic             port_reset_async,
    output      logic             internal_reset,
    output      sarc_gates_type   gates,
    output      sarc_sleep_type   sleep_out
);

    sarc_state_type   s_r;
    sarc_state_type   s_nxt;
    sarc_rst_src_type src_meta_r;
    sarc_rst_src_type src_sync_r;
    logic             wdog_prev_r;
    logic             any_src;

    function automatic logic [7:0] apply_strb(input logic [7:0] old_v,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
        apply_strb = strb[0] ? data[7:0] : old_v;
    endfunction

    function automatic logic [31:0] tout_cycles(input logic [1:0] st_fuse,
                                                input logic [3:0] cs_fuse);
        unique case (st_fuse)
            2'b00:   tout_cycles = SARC_TOUT_SHORT_US * SARC_CYC_PER_US;
            2'b01:   tout_cycles = TOUT_MID_CYCLES;
            default: tout_cycles = (cs_fuse[0]) ? TOUT_MID_CYCLES : TOUT_LONG_CYCLES;
        endcase
    endfunction

    // Any active source asserts the port reset with no clock at all
    assign any_src = rst_src.power_on | ~rst_src.external_n | rst_src.watchdog
                   | rst_src.brownout | rst_src.scan;
    assign port_reset_async = any_src;

    // Two-stage synchronisers on the source levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_meta_r  <= '0;
            src_sync_r  <= '0;
            wdog_prev_r <= 1'b0;
        end else begin
            src_meta_r  <= '{power_on: rst_src.power_on, external_n: ~rst_src.external_n,
                             watchdog: rst_src.watchdog, brownout: rst_src.brownout,
                             scan: rst_src.scan};
            src_sync_r  <= src_meta_r;
            wdog_prev_r <= src_sync_r.watchdog;
        end
    end

    always_comb begin
        logic        sync_any;
        logic [31:0] rd;
        logic        wr_fire;
        logic        unlock_req;
        s_nxt      = s_r;
        rd         = '0;
        sync_any   = src_sync_r.power_on | src_sync_r.external_n | src_sync_r.watchdog
                   | src_sync_r.brownout | src_sync_r.scan;
        unlock_req = 1'b0;
        wr_fire    = 1'b0;

        // Reset sequencer: hold while any source, then delay, then run
        unique case (s_r.rst_state)
            SARC_RST_HOLD: begin
                if (!sync_any) begin
                    s_nxt.rst_state = SARC_RST_DELAY;
                    s_nxt.delay_cnt = tout_cycles(startup_time_fuse, clock_select_fuse);
                end
            end
            SARC_RST_DELAY: begin
                if (sync_any) begin
                    s_nxt.rst_state = SARC_RST_HOLD;
                end else if (s_r.delay_cnt == '0) begin
                    s_nxt.rst_state = SARC_RST_RUN;
                end else begin
                    s_nxt.delay_cnt = s_r.delay_cnt - 32'd1;
                end
            end
            SARC_RST_RUN: begin
                if (sync_any) begin
                    s_nxt.rst_state = SARC_RST_HOLD;
                end
            end
            default: s_nxt.rst_state = SARC_RST_HOLD;
        endcase

        // Control registers return to initial values while any synced reset source is active
        if (sync_any) begin
            s_nxt.smc        = SARC_SMC_RESET;
            s_nxt.sysctl     = SARC_REG_RESET;
            s_nxt.gate0      = SARC_REG_RESET;
            s_nxt.gate1      = SARC_REG_RESET;
            s_nxt.bo_active  = 1'b0;
            s_nxt.bo_cnt     = '0;
            s_nxt.unlock_cnt = '0;
            s_nxt.sleeping   = 1'b0;
        end

        // Brown-out-off: three cycles to take effect, three to self-clear
        if (s_r.unlock_cnt != '0) s_nxt.unlock_cnt = s_r.unlock_cnt - 3'd1;
        if (s_r.sysctl[SARC_BO_OFF_BIT]) begin
            if (s_r.bo_cnt == SARC_BO_DELAY + SARC_BO_HOLD - 3'd1) begin
                s_nxt.sysctl[SARC_BO_OFF_BIT] = 1'b0;
                s_nxt.bo_active = 1'b0;
                s_nxt.bo_cnt    = '0;
            end else begin
                s_nxt.bo_cnt = s_r.bo_cnt + 3'd1;
                if (s_r.bo_cnt == SARC_BO_DELAY - 3'd1) s_nxt.bo_active = 1'b1;
            end
        end

        // Sleep entry; wake is any register write or a new reset
        if (sleep_instr && s_r.smc[SARC_SLEEP_ARM_BIT] && !s_r.sleeping) begin
            s_nxt.sleeping          = 1'b1;
            s_nxt.sleep_mode        = sarc_mode_type'(s_r.smc[SARC_SLEEP_MODE_LSB +: 3]);
            s_nxt.bo_sleep_latched  = s_r.bo_active;
        end

        // AXI write channel, either order
        if (s_axi_awvalid && !s_r.aw_got && !s_r.bvalid) begin
            s_nxt.aw_got  = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_got && !s_r.bvalid) begin
            s_nxt.w_got  = 1'b1;
            s_nxt.w_data = s_axi_wdata;
            s_nxt.w_strb = s_axi_wstrb;
        end
        wr_fire = s_r.aw_got && s_r.w_got;
        if (wr_fire) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = SARC_AXI_OKAY;
            s_nxt.sleeping = 1'b0;
            unique case (s_r.aw_addr)
                SARC_ADDR_SMC:
                    s_nxt.smc = apply_strb(s_r.smc, s_r.w_data, s_r.w_strb) & SARC_SMC_MASK;
                SARC_ADDR_SYSTEM_CONTROL: begin
                    if (s_r.w_strb[0]) begin
                        // Unlock write opens the window; off bit only via second write
                        if (s_r.w_data[SARC_BO_OFF_BIT] && s_r.w_data[SARC_BO_UNLOCK_BIT]) begin
                            unlock_req = 1'b1;
                        end else if (s_r.w_data[SARC_BO_OFF_BIT] && s_r.unlock_cnt != '0) begin
                            s_nxt.sysctl[SARC_BO_OFF_BIT] = 1'b1;
                            s_nxt.bo_cnt     = '0;
                            s_nxt.unlock_cnt = '0;
                        end
                    end
                end
                SARC_ADDR_GATE_0:
                    s_nxt.gate0 = apply_strb(s_r.gate0, s_r.w_data, s_r.w_strb);
                SARC_ADDR_GATE_1:
                    s_nxt.gate1 = apply_strb(s_r.gate1, s_r.w_data, s_r.w_strb)
                                & SARC_G1_MASK;
                SARC_ADDR_RESET_STATUS: begin
                    // Software may only clear flags; a live source still wins
                    if (s_r.w_strb[0]) s_nxt.rflags = s_r.rflags & s_r.w_data[4:0];
                end
                default: s_nxt.bresp = SARC_AXI_SLVERR;
            endcase
        end
        if (unlock_req) s_nxt.unlock_cnt = SARC_UNLOCK_WINDOW;
        if (s_r.bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;

        // Cause flags after the software clear, so a live set wins
        if (src_sync_r.power_on) begin
            s_nxt.rflags = SARC_RF_POR;
        end else begin
            if (src_sync_r.external_n) s_nxt.rflags[SARC_RF_EXTERNAL] = 1'b1;
            if (src_sync_r.brownout)   s_nxt.rflags[SARC_RF_BROWNOUT] = 1'b1;
            if (src_sync_r.scan)       s_nxt.rflags[SARC_RF_SCAN]     = 1'b1;
        end

        // Watchdog flag set while its synced pulse is high and on its falling edge, after clears
        if (wdog_prev_r && !src_sync_r.watchdog) s_nxt.rflags[SARC_RF_WATCHDOG] = 1'b1;
        if (src_sync_r.watchdog) s_nxt.rflags[SARC_RF_WATCHDOG] = 1'b1;

        // AXI read channel
        if (s_axi_arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = SARC_AXI_OKAY;
            unique case (s_axi_araddr)
                SARC_ADDR_SMC:            rd = {24'h000000, s_r.smc};
                SARC_ADDR_SYSTEM_CONTROL: rd = {24'h000000, s_r.sysctl};
                SARC_ADDR_GATE_0:         rd = {24'h000000, s_r.gate0};
                SARC_ADDR_GATE_1:         rd = {24'h000000, s_r.gate1};
                SARC_ADDR_RESET_STATUS:   rd = {27'h0, s_r.rflags};
                SARC_ADDR_SLEEP_STATUS:
                    rd = {26'h0, s_r.bo_sleep_latched, s_r.bo_active,
                          s_r.sleep_mode, s_r.sleeping};
                default: s_nxt.rresp = SARC_AXI_SLVERR;
            endcase
            s_nxt.rdata = rd;
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r           <= '0;
            s_r.rst_state <= SARC_RST_HOLD;
            s_r.rflags    <= SARC_RF_POR;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
    assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;

    assign internal_reset = (s_r.rst_state != SARC_RST_RUN);

    // Gated modules keep frozen state; clearing the bit resumes them
    assign gates.gate_two_wire_port  = s_r.gate0[SARC_G0_TWO_WIRE];
    assign gates.gate_timer_2        = s_r.gate0[SARC_G0_TIMER_2]
                                     & ~timer2_async_select;
    assign gates.gate_timer_0        = s_r.gate0[SARC_G0_TIMER_0];
    assign gates.gate_serial_port_1  = s_r.gate0[SARC_G0_SERIAL_1];
    assign gates.gate_timer_1        = s_r.gate0[SARC_G0_TIMER_1];
    assign gates.gate_spi_port       = s_r.gate0[SARC_G0_SPI];
    assign gates.gate_serial_port_0  = s_r.gate0[SARC_G0_SERIAL_0];
    assign gates.gate_converter      = s_r.gate0[SARC_G0_CONVERTER];
    assign gates.gate_timer_3        = s_r.gate1[SARC_G1_TIMER_3];
    assign gates.comparator_mux_deny = s_r.gate0[SARC_G0_CONVERTER];

    assign sleep_out.sleep_active = s_r.sleeping;
    assign sleep_out.sleep_mode   = s_r.sleep_mode;
    assign sleep_out.brownout_off = s_r.sleeping & s_r.bo_sleep_latched;

endmodule

/* File: verilog/sarc_pkg.sv */
/*
  Shared constants and types for the sleep and reset control block.
  Assumes a 32-bit AXI4-Lite register bus and one 250 MHz system clock.
*/
package sarc_pkg;

    localparam logic [31:0] SARC_CLK_HZ = 32'd250_000_000;

    // Register byte addresses
    // Printed offset is a word index; byte address is four times it
    localparam logic [7:0] SARC_IDX_SLEEP_MODE_CONTROL  = 8'h33;
    localparam logic [7:0] SARC_ADDR_SLEEP_MODE_CONTROL = SARC_IDX_SLEEP_MODE_CONTROL << 2;
    localparam logic [7:0] SARC_ADDR_SMC                = SARC_ADDR_SLEEP_MODE_CONTROL;
    localparam logic [7:0] SARC_ADDR_SYSTEM_CONTROL     = 8'hD0;
    localparam logic [7:0] SARC_ADDR_GATE_0             = 8'hD4;
    localparam logic [7:0] SARC_ADDR_GATE_1             = 8'hD8;
    localparam logic [7:0] SARC_ADDR_RESET_STATUS       = 8'hDC;
    localparam logic [7:0] SARC_ADDR_SLEEP_STATUS       = 8'hE0;

    // Field positions
    localparam int SARC_SLEEP_ARM_BIT       = 0;
    localparam int SARC_SLEEP_MODE_LSB      = 1;
    localparam int SARC_BO_OFF_BIT          = 6;
    localparam int SARC_BO_UNLOCK_BIT       = 5;
    localparam int SARC_G0_TWO_WIRE         = 7;
    localparam int SARC_G0_TIMER_2          = 6;
    localparam int SARC_G0_TIMER_0          = 5;
    localparam int SARC_G0_SERIAL_1         = 4;
    localparam int SARC_G0_TIMER_1          = 3;
    localparam int SARC_G0_SPI              = 2;
    localparam int SARC_G0_SERIAL_0         = 1;
    localparam int SARC_G0_CONVERTER        = 0;
    localparam int SARC_G1_TIMER_3          = 0;
    localparam int SARC_RF_POWER_ON         = 0;
    localparam int SARC_RF_EXTERNAL         = 1;
    localparam int SARC_RF_BROWNOUT         = 2;
    localparam int SARC_RF_WATCHDOG         = 3;
    localparam int SARC_RF_SCAN             = 4;

    localparam logic [7:0] SARC_SMC_RESET   = 8'h00;
    localparam logic [7:0] SARC_SMC_MASK    = 8'h0F;
    localparam logic [7:0] SARC_G1_MASK     = 8'h01;
    localparam logic [7:0] SARC_RF_MASK     = 8'h1F;
    localparam logic [7:0] SARC_REG_RESET   = 8'h00;
    localparam logic [4:0] SARC_RF_POR      = 5'h01;

    // Timed unlock and brown-out-off timing, in system clock cycles
    localparam logic [2:0] SARC_UNLOCK_WINDOW = 3'd4;
    localparam logic [2:0] SARC_BO_DELAY      = 3'h3;
    localparam logic [2:0] SARC_BO_HOLD       = 3'h3;

    // Start-up delay choices in microseconds, picked by fuses
    localparam logic [31:0] SARC_TOUT_SHORT_US = 32'd0;
    localparam logic [31:0] SARC_TOUT_MID_US   = 32'd4100;
    localparam logic [31:0] SARC_TOUT_LONG_US  = 32'd65000;
    localparam logic [31:0] SARC_CYC_PER_US    = SARC_CLK_HZ / 32'd1_000_000;

    localparam logic [1:0] SARC_AXI_OKAY   = 2'b00;
    localparam logic [1:0] SARC_AXI_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        SARC_MODE_IDLE      = 3'b000,
        SARC_MODE_NOISE_RED = 3'b001,
        SARC_MODE_PWR_DOWN  = 3'b010,
        SARC_MODE_PWR_SAVE  = 3'b011,
        SARC_MODE_RSVD_4    = 3'b100,
        SARC_MODE_RSVD_5    = 3'b101,
        SARC_MODE_STANDBY   = 3'b110,
        SARC_MODE_EXT_STBY  = 3'b111
    } sarc_mode_type;

    typedef enum logic [2:0] {
        SARC_RST_HOLD  = 3'b001,
        SARC_RST_DELAY = 3'b010,
        SARC_RST_RUN   = 3'b100
    } sarc_rst_state_type;

    typedef struct packed {
        logic gate_two_wire_port;
        logic gate_timer_2;
        logic gate_timer_0;
        logic gate_serial_port_1;
        logic gate_timer_1;
        logic gate_spi_port;
        logic gate_serial_port_0;
        logic gate_converter;
        logic gate_timer_3;
        logic comparator_mux_deny;
    } sarc_gates_type;

    typedef struct packed {
        logic          sleep_active;
        sarc_mode_type sleep_mode;
        logic          brownout_off;
    } sarc_sleep_type;

    typedef struct packed {
        logic power_on;
        logic external_n;
        logic watchdog;
        logic brownout;
        logic scan;
    } sarc_rst_src_type;

    typedef struct packed {
        logic [7:0]         smc;
        logic [7:0]         sysctl;
        logic [7:0]         gate0;
        logic [7:0]         gate1;
        logic [4:0]         rflags;
        logic [2:0]         unlock_cnt;
        logic [2:0]         bo_cnt;
        logic               bo_active;
        logic               bo_sleep_latched;
        logic               sleeping;
        sarc_mode_type      sleep_mode;
        sarc_rst_state_type rst_state;
        logic [31:0]        delay_cnt;
        logic               aw_got;
        logic               w_got;
        logic [7:0]         aw_addr;
        logic [31:0]        w_data;
        logic [3:0]         w_strb;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
    } sarc_state_type;

endpackage

/* File: verif/sarc_chk.sv */
/*
  Concurrent checks for the sleep and reset control block.
  Assumes it is bound to sarc_top and sees only its ports, one aclk domain.
*/
`timescale 1ns/1ps
module sarc_chk
    import sarc_pkg::*;
#(
    parameter logic [31:0] TOUT_MID_CYCLES  = 32'h8,
    parameter logic [31:0] TOUT_LONG_CYCLES = 32'h8
) (
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic             sleep_instr,
    input wire logic             timer2_async_select,
    input wire sarc_rst_src_type rst_src,
    input wire logic             port_reset_async,
    input wire logic             internal_reset,
    input wire sarc_gates_type   gates,
    input wire sarc_sleep_type   sleep_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic src_any;
    assign src_any = rst_src.power_on | ~rst_src.external_n | rst_src.watchdog
                   | rst_src.brownout | rst_src.scan;

    // Sources gone and staying gone for eight cycles after the fall
    sequence s_src_gone;
        $fell(port_reset_async) ##1 (!port_reset_async)[*8];
    endsequence

    property p_port_or;   port_reset_async == src_any; endproperty
    property p_rst_set;   $rose(port_reset_async) |-> ##[1:4] internal_reset; endproperty
    property p_rst_hold;  $fell(port_reset_async) |-> ##3 internal_reset[*6]; endproperty
    property p_rst_free;  s_src_gone |-> ##[0:20] !internal_reset; endproperty
    property p_reg_clr;   port_reset_async[*5] |-> gates == '0; endproperty
    property p_t2;        gates.gate_timer_2 |-> !timer2_async_select; endproperty
    property p_cmp;       gates.gate_converter |-> gates.comparator_mux_deny; endproperty
    property p_arm;       $rose(sleep_out.sleep_active) |-> $past(sleep_instr); endproperty
    property p_bo_off;    sleep_out.brownout_off |-> sleep_out.sleep_active; endproperty
    property p_rstand;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty

    a_port_or:  assert property (p_port_or)  else $error("port reset not OR of sources");
    a_rst_set:  assert property (p_rst_set)  else $error("internal reset late");
    a_rst_hold: assert property (p_rst_hold) else $error("internal reset released early");
    a_rst_free: assert property (p_rst_free) else $error("internal reset stuck");
    a_reg_clr:  assert property (p_reg_clr)  else $error("gates not cleared by reset");
    a_t2:       assert property (p_t2)       else $error("timer 2 gated while async");
    a_cmp:      assert property (p_cmp)      else $error("comparator mux not denied");
    a_arm:      assert property (p_arm)      else $error("sleep without instruction");
    a_bo_off:   assert property (p_bo_off)   else $error("detector off outside sleep");
    a_rstand:   assert property (p_rstand)   else $error("read data dropped");
endmodule

bind sarc_top sarc_chk #(.TOUT_MID_CYCLES(TOUT_MID_CYCLES), .TOUT_LONG_CYCLES(TOUT_LONG_CYCLES))
    u_chk (.aclk, .aresetn, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sleep_instr,
           .timer2_async_select, .rst_src, .port_reset_async, .internal_reset, .gates,
           .sleep_out);

/* File: verif/sarc_bench.sv */
/*
  Self-checking bench for the sleep and reset control block.
  Assumes the short start-up delay parameters of 8 cycles and fuse 2'b10.
*/
`timescale 1ns/1ps
module sarc_bench
    import sarc_pkg::*;
;
    logic             aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic             sleep_instr, t2_async, awready, wready, bvalid, arready, rvalid;
    logic             port_rst, int_rst;
    logic [7:0]       awaddr, araddr;
    logic [31:0]      wdata, rdata;
    logic [1:0]       bresp, rresp;
    sarc_rst_src_type src;
    sarc_gates_type   gates;
    sarc_sleep_type   slp;
    int               err_count, n_tests;

    sarc_top #(.TOUT_MID_CYCLES(32'h8), .TOUT_LONG_CYCLES(32'h8)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleep_instr(sleep_instr), .timer2_async_select(t2_async),
        .startup_time_fuse(2'h2), .clock_select_fuse(4'h0), .rst_src(src),
        .port_reset_async(port_rst), .internal_reset(int_rst), .gates(gates),
        .sleep_out(slp));

    task automatic end_sim();
        if (err_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Handshakes judged at negedge, where readies have settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        b_hs = 1'b0;
        while (!b_hs) begin
            @(negedge aclk);
            aw_hs = awvalid & awready;
            w_hs = wvalid & wready;
            b_hs = bvalid & bready;
            r = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_hs) bready <= 1'b0;
        end
        @(posedge aclk);
    endtask

    // Ready raised only after valid, so the slave must hold its answer
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs, rv;
        araddr <= a;
        arvalid <= 1'b1;
        r_hs = 1'b0;
        while (!r_hs) begin
            @(negedge aclk);
            ar_hs = arvalid & arready;
            r_hs = rvalid & rready;
            rv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
            rready <= rv & ~r_hs;
        end
        @(posedge aclk);
    endtask

    task automatic wrc(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        cmp("bresp", {30'h0, SARC_AXI_OKAY}, {30'h0, r});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        cmp("rdata", e, d);
        cmp("rresp", {30'h0, SARC_AXI_OKAY}, {30'h0, r});
    endtask

    task automatic slp_go(output sarc_sleep_type s);
        sleep_instr <= 1'b1;
        @(posedge aclk);
        sleep_instr <= 1'b0;
        @(posedge aclk);
        @(negedge aclk);
        s = slp;
        @(posedge aclk);
    endtask

    task automatic wait_rel(output int n);
        n = 0;
        @(negedge aclk);
        // Synced sources raise internal reset a few cycles late
        while (int_rst !== 1'b1) @(negedge aclk);
        while (int_rst !== 1'b0) begin
            n++;
            @(negedge aclk);
        end
        @(posedge aclk);
    endtask

    function automatic sarc_gates_type exp_gates(input logic [7:0] g0, input logic [7:0] g1,
                                                 input logic a);
        exp_gates = {g0[7], g0[6] & ~a, g0[5:0], g1[0], g0[0]};
    endfunction

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    initial begin
        #40000;
        err_count++;
        end_sim();
    end

    initial begin
        sarc_sleep_type s;
        logic [7:0]     g0, g1;
        logic [31:0]    d;
        logic [1:0]     r;
        logic [4:0]     flg;
        int             hits, cnt;
        err_count = 0;
        n_tests = 0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_instr, t2_async} = '0;
        {awaddr, araddr, wdata} = '0;
        src = 5'h08;
        void'($urandom(32'ha86a4bee));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        wait_rel(cnt);
        cmp("delay_span_start", 32'h1, {31'h0, cnt >= 8 && cnt <= 16});
        for (int i = 0; i < 6; i++) rdc(SARC_ADDR_SMC + 8'(i * 4), (i == 4) ? 32'h1 : 32'h0);
        wr(8'h10, 32'hFF, r);
        cmp("bresp_unmapped", {30'h0, SARC_AXI_SLVERR}, {30'h0, r});
        rd(8'h10, d, r);
        cmp("rresp_unmapped", {30'h0, SARC_AXI_SLVERR}, {30'h0, r});
        // Reserved modes are written but not read back: their storage is unspecified
        for (int m = 0; m < 8; m++) begin
            wrc(SARC_ADDR_SMC, 32'(m * 2 + 1));
            if (m == 4 || m == 5) continue;
            rdc(SARC_ADDR_SMC, 32'(m * 2 + 1));
            slp_go(s);
            cmp("sleep_out", {27'h0, 1'b1, 3'(m), 1'b0}, {27'h0, s});
            wrc(SARC_ADDR_SMC, 32'(m * 2));
            slp_go(s);
            cmp("sleep_disarmed", 32'h0, {31'h0, s.sleep_active});
        end
        // Proper unlock, missing unlock, late second write
        for (int v = 0; v < 3; v++) begin
            hits = 0;
            for (int k = 0; k < 8; k++) begin
                wrc(SARC_ADDR_SMC, 32'h1);
                if (v != 1) wrc(SARC_ADDR_SYSTEM_CONTROL, 32'h60);
                if (v == 2) repeat (8) @(posedge aclk);
                wrc(SARC_ADDR_SYSTEM_CONTROL, 32'h40);
                repeat (k) @(posedge aclk);
                slp_go(s);
                hits += s.brownout_off;
            end
            cmp("bo_off_hits", (v == 0) ? 32'h3 : 32'h0, 32'(hits));
        end
        for (int i = 0; i < 10; i++) begin
            g0 = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom());
            g1 = 8'($urandom());
            t2_async <= 1'($urandom());
            wrc(SARC_ADDR_GATE_0, {24'h0, g0});
            wrc(SARC_ADDR_GATE_1, {24'h0, g1});
            rdc(SARC_ADDR_GATE_0, {24'h0, g0});
            rdc(SARC_ADDR_GATE_1, {24'h0, g1 & SARC_G1_MASK});
            @(negedge aclk);
            cmp("gates", {22'h0, exp_gates(g0, g1, t2_async)}, {22'h0, gates});
            @(posedge aclk);
        end
        wrc(SARC_ADDR_RESET_STATUS, 32'h0);
        rdc(SARC_ADDR_RESET_STATUS, 32'h0);
        flg = 5'h0;
        // Order: power-on, pin, watchdog (one cycle), brown-out, scan
        for (int i = 0; i < 5; i++) begin
            wrc(SARC_ADDR_GATE_0, 32'hFF);
            src <= src ^ (5'h10 >> i);
            @(negedge aclk);
            cmp("port_reset", 32'h1, {31'h0, port_rst});
            if (i != 2) repeat (6) @(negedge aclk);
            @(posedge aclk);
            src <= src ^ (5'h10 >> i);
            wait_rel(cnt);
            cmp("delay_span", 32'h1, {31'h0, cnt >= 8 && cnt <= 16});
            flg = (i == 0) ? 5'h01 : flg | (5'h1 << ((i == 2) ? 3 : (i == 3) ? 2 : i));
            rdc(SARC_ADDR_GATE_0, 32'h0);
            rdc(SARC_ADDR_RESET_STATUS, {27'h0, flg});
        end
        end_sim();
    end
endmodule
